// *** core/mfa_params.svh ***
`ifndef MFA_PARAMS_SVH
`define MFA_PARAMS_SVH
// =====================================
// Register map (byte addresses)
`define MFA_ADDR_SEL1 4'h0
`define MFA_ADDR_SEL2 4'h4
`define MFA_ADDR_SER 4'h8
`define MFA_ADDR_STAT 4'hc
`define MFA_RST_SEL1 32'h0001_143c
`define MFA_RST_SEL2 32'h0000_0000
`define MFA_RST_SER 32'h0000_00f5
// =====================================
// Select bits, first selection word
`define MFA_S1_RAW 0
`define MFA_S1_COR 1
`define MFA_S1_EXP 2
`define MFA_S1_CNT 3
`define MFA_S1_TS 4
`define MFA_S1_TMP 5
`define MFA_S1_INT 8
`define MFA_S1_DSP 10
`define MFA_S1_PK1 12
`define MFA_S1_PK2 13
`define MFA_S1_STS 16
`define MFA_S1_TRG 19
// Second selection word; serial enable bit in the serial configuration word
`define MFA_S2_DIF 0
`define MFA_S2_MIN 6
`define MFA_S2_MAX 7
`define MFA_S2_P2P 8
`define MFA_SER_EN 8
// =====================================
// Word slots, in emission order
`define MFA_SL_EXP 4'h0
`define MFA_SL_CNT 4'h1
`define MFA_SL_TS 4'h2
`define MFA_SL_TMP 4'h3
`define MFA_SL_I1 4'h4
`define MFA_SL_D1 4'h5
`define MFA_SL_I2 4'h6
`define MFA_SL_D2 4'h7
`define MFA_SL_STS 4'h8
`define MFA_SL_TRG 4'h9
`define MFA_SL_DIF 4'ha
`define MFA_SL_MIN 4'hb
`define MFA_SL_MAX 4'hc
`define MFA_SL_P2P 4'hd
`define MFA_SL_NONE 4'hf
`define MFA_NSLOT 14
// =====================================
// Video and temperature limits, bus response codes
`define MFA_PIX_LAST 10'h1ff
`define MFA_PIX_W 16
`define MFA_TMP_MIN 10'h324
`define MFA_TMP_MAX 10'h1fc
`define MFA_RESP_OK 2'h0
`define MFA_RESP_ERR 2'h2
`endif

// *** core/mfa_pkg.sv ***
package mfa_pkg;
   typedef enum logic [2:0] {
      MFA_IDLE = 3'b001,
      MFA_VIDEO = 3'b010,
      MFA_WORDS = 3'b100
   } mfa_pkt_state_t;
   typedef enum logic [1:0] {
      MFA_SIDLE = 2'b01,
      MFA_SSEND = 2'b10
   } mfa_ser_state_t;
   typedef logic [3:0] mfa_slot_t;
endpackage

// *** core/measurement_frame_assembler.sv ***
`timescale 1ns/1ps
`include "mfa_params.svh"
// Summary of operation
// - Frame holds only selected fields, no padding
// - Fixed field order; video 512 pixels 16 bits
// - Intensity word precedes its displacement word
// - Two video signals interleaved pixel by pixel
// - Exposure in bits 16:0, 12.5 ns steps
// - Serial exposure sends bits 0..16 only
// - Sample counter in bits 23:0
// - Serial counter sends bits 0..17, wraps
// - Time stamp full 32 bits, 1 us
// - Serial time stamp sends bits 8..25
// - Temperature 10-bit signed, sign-extended
// - Temperature clamped to -55..+127 degrees
// - Displacement, difference signed 32-bit nanometres
// - Serial displacement uses 18-bit code field
// - Intensity: peak 24:14, raw 9:0
// - Serial intensity sends bits 0..9
// - Status layout: LED, trigger, error flags
// - Serial status sends bits 0..17
// - Trigger counter word layout
// - Trigger counter never sent serially
// - Serial: no video, two values maximum
// - Difference uses displacement format
// - Statistics order minimum, maximum, peak-to-peak
// - Serial values split into flagged bytes
module measurement_frame_assembler (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic [3:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [3:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic sampleValid,
   input wire logic [16:0] exposureTime,
   input wire logic [23:0] sampleCount,
   input wire logic [31:0] timeStamp,
   input wire logic [9:0] temperatureQ,
   input wire logic [31:0] displacement1,
   input wire logic [31:0] displacement2,
   input wire logic [10:0] peakMax1,
   input wire logic [9:0] rawIntensity1,
   input wire logic [10:0] peakMax2,
   input wire logic [9:0] rawIntensity2,
   input wire logic [1:0] ledColour,
   input wire logic triggerFlag,
   input wire logic [6:0] errorFlags,
   input wire logic triggerId,
   input wire logic [13:0] trigger_event_count,
   input wire logic [13:0] triggered_sample_count,
   input wire logic [31:0] difference,
   input wire logic [31:0] statMin,
   input wire logic [31:0] statMax,
   input wire logic [31:0] peak_to_peak_statistic,
   output logic [8:0] pixAddr,
   input wire logic [15:0] pixRaw,
   input wire logic [15:0] pixCorrected,
   output logic [31:0] pktData,
   output logic pktValid,
   output logic pktLast,
   input wire logic pktReady,
   output logic [7:0] serByte,
   output logic serValid,
   input wire logic serReady
);
   // =====================================
   // Functions
   function automatic logic [31:0] wrStrobe(input logic [31:0] old, input logic [31:0] d,
                                            input logic [3:0] strb);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) begin
            r[b*8 +: 8] = d[b*8 +: 8];
         end
      end
      return r;
   endfunction

   function automatic mfa_pkg::mfa_slot_t firstFrom(input logic [13:0] m,
                                                     input logic [4:0] from);
      mfa_pkg::mfa_slot_t r;
      r = `MFA_SL_NONE;
      for (int i = `MFA_NSLOT - 1; i >= 0; i--) begin
         if (m[i] && (5'(i) >= from)) begin
            r = 4'(i);
         end
      end
      return r;
   endfunction

   function automatic logic [17:0] serTrunc(input mfa_pkg::mfa_slot_t s, input logic [31:0] w);
      logic [17:0] r;
      r = w[17:0];
      if (s == `MFA_SL_EXP) begin
         r = {1'b0, w[16:0]};
      end else if (s == `MFA_SL_TS) begin
         r = w[25:8];
      end else if ((s == `MFA_SL_I1) || (s == `MFA_SL_I2)) begin
         r = {8'h00, w[9:0]};
      end
      return r;
   endfunction

   function automatic logic serOk(input mfa_pkg::mfa_slot_t s);
      return (s != `MFA_SL_TRG) && (s < 4'(`MFA_NSLOT));
   endfunction

   // =====================================
   // Registers and state
   logic [31:0] sel1_r, sel2_r, serCfg_r;
   logic [15:0] dropCnt_r, frameCnt_r;
   logic [31:0] frameWord_r [0:`MFA_NSLOT-1];
   logic [13:0] mask_r;
   logic [1:0] vidSel_r;
   mfa_pkg::mfa_pkt_state_t pktState_r;
   mfa_pkg::mfa_slot_t slot_r;
   logic [9:0] vidCnt_r;
   logic [31:0] pktData_r;
   logic pktValid_r, pktLast_r;
   mfa_pkg::mfa_ser_state_t serState_r;
   mfa_pkg::mfa_slot_t serCode0_r, serCode1_r;
   logic serTwo_r, serVal_r;
   logic [1:0] serPos_r;
   logic [7:0] serByte_r;
   logic serValid_r;
   logic bvalid_r, rvalid_r;
   logic [1:0] bresp_r, rresp_r;
   logic [31:0] rdata_r;

   // =====================================
   // Bus decode
   wire wrFire = s_axi_awvalid & s_axi_wvalid & ~bvalid_r;
   wire rdFire = s_axi_arvalid & ~rvalid_r;
   wire wrSel1 = wrFire & (s_axi_awaddr == `MFA_ADDR_SEL1);
   wire wrSel2 = wrFire & (s_axi_awaddr == `MFA_ADDR_SEL2);
   wire wrSer = wrFire & (s_axi_awaddr == `MFA_ADDR_SER);
   wire wrMapped = wrSel1 | wrSel2 | wrSer | (s_axi_awaddr == `MFA_ADDR_STAT);
   wire pktBusy = (pktState_r != mfa_pkg::MFA_IDLE);
   wire serBusy = (serState_r != mfa_pkg::MFA_SIDLE);
   wire [31:0] statWord = {dropCnt_r, frameCnt_r[13:0], serBusy, pktBusy};
   wire rdMapped = (s_axi_araddr == `MFA_ADDR_SEL1) | (s_axi_araddr == `MFA_ADDR_SEL2) |
                   (s_axi_araddr == `MFA_ADDR_SER) | (s_axi_araddr == `MFA_ADDR_STAT);
   wire [31:0] rdMux = (s_axi_araddr == `MFA_ADDR_SEL1) ? sel1_r :
                       (s_axi_araddr == `MFA_ADDR_SEL2) ? sel2_r :
                       (s_axi_araddr == `MFA_ADDR_SER) ? serCfg_r :
                       (s_axi_araddr == `MFA_ADDR_STAT) ? statWord : 32'h0000_0000;

   assign s_axi_awready = wrFire;
   assign s_axi_wready = wrFire;
   assign s_axi_bvalid = bvalid_r;
   assign s_axi_bresp = bresp_r;
   assign s_axi_arready = rdFire;
   assign s_axi_rvalid = rvalid_r;
   assign s_axi_rresp = rresp_r;
   assign s_axi_rdata = rdata_r;

   // =====================================
   // Field selection and word formatting
   wire pk1 = sel1_r[`MFA_S1_PK1];
   wire pk2 = sel1_r[`MFA_S1_PK2];
   wire dspOn = sel1_r[`MFA_S1_DSP];
   wire intOn = sel1_r[`MFA_S1_INT] & dspOn;
   wire [13:0] selMask = {sel2_r[`MFA_S2_P2P], sel2_r[`MFA_S2_MAX], sel2_r[`MFA_S2_MIN],
                          sel2_r[`MFA_S2_DIF] & pk1 & pk2,
                          sel1_r[`MFA_S1_TRG], sel1_r[`MFA_S1_STS],
                          dspOn & pk2, intOn & pk2, dspOn & pk1, intOn & pk1,
                          sel1_r[`MFA_S1_TMP], sel1_r[`MFA_S1_TS],
                          sel1_r[`MFA_S1_CNT], sel1_r[`MFA_S1_EXP]};
   wire tmpLow = $signed(temperatureQ) < $signed(`MFA_TMP_MIN);
   wire tmpHigh = $signed(temperatureQ) > $signed(`MFA_TMP_MAX);
   wire [9:0] tmpClamp = tmpLow ? `MFA_TMP_MIN : (tmpHigh ? `MFA_TMP_MAX : temperatureQ);
   logic [31:0] fmtWord [0:`MFA_NSLOT-1];
   assign fmtWord[`MFA_SL_EXP] = {15'h0000, exposureTime};
   assign fmtWord[`MFA_SL_CNT] = {8'h00, sampleCount};
   assign fmtWord[`MFA_SL_TS] = timeStamp;
   assign fmtWord[`MFA_SL_TMP] = {{22{tmpClamp[9]}}, tmpClamp};
   assign fmtWord[`MFA_SL_I1] = {7'h00, peakMax1, 4'h0, rawIntensity1};
   assign fmtWord[`MFA_SL_D1] = displacement1;
   assign fmtWord[`MFA_SL_I2] = {7'h00, peakMax2, 4'h0, rawIntensity2};
   assign fmtWord[`MFA_SL_D2] = displacement2;
   assign fmtWord[`MFA_SL_STS] = {14'h0000, ledColour, triggerFlag, 8'h00, errorFlags};
   assign fmtWord[`MFA_SL_TRG] = {triggerId, 1'b0, trigger_event_count, 2'h0,
                                  triggered_sample_count};
   assign fmtWord[`MFA_SL_DIF] = difference;
   assign fmtWord[`MFA_SL_MIN] = statMin;
   assign fmtWord[`MFA_SL_MAX] = statMax;
   assign fmtWord[`MFA_SL_P2P] = peak_to_peak_statistic;

   // =====================================
   // Capture: the latched frame must not move while either link drains it
   wire capture = sampleValid & ~pktBusy & ~serBusy;
   wire [1:0] vidSelNow = {sel1_r[`MFA_S1_COR], sel1_r[`MFA_S1_RAW]};
   wire [3:0] firstNow = firstFrom(selMask, 5'h00);
   wire [3:0] cfgCode0 = serCfg_r[3:0];
   wire [3:0] cfgCode1 = serCfg_r[7:4];
   wire ok0 = serOk(cfgCode0);
   wire ok1 = serOk(cfgCode1);
   wire serStart = serCfg_r[`MFA_SER_EN] & (ok0 | ok1);

   // =====================================
   // Packet link
   wire pktAdv = ~pktValid_r | pktReady;
   wire vidDual = &vidSel_r;
   wire [15:0] vidOne = vidSel_r[1] ? pixCorrected : pixRaw;
   wire [31:0] vidWord = vidDual ? {pixCorrected, pixRaw} : {16'h0000, vidOne};
   wire vidDone = (vidCnt_r > {1'b0, `MFA_PIX_LAST});
   wire vidLastPix = (vidCnt_r == {1'b0, `MFA_PIX_LAST});
   wire [3:0] slotNext = firstFrom(mask_r, {1'b0, slot_r} + 5'h01);

   assign pixAddr = vidCnt_r[8:0];
   assign pktData = pktData_r;
   assign pktValid = pktValid_r;
   assign pktLast = pktLast_r;

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         pktState_r <= mfa_pkg::MFA_IDLE;
         pktValid_r <= 1'b0;
         pktLast_r <= 1'b0;
         pktData_r <= 32'h0000_0000;
         slot_r <= `MFA_SL_NONE;
         vidCnt_r <= 10'h000;
         mask_r <= 14'h0000;
         vidSel_r <= 2'h0;
         frameCnt_r <= 16'h0000;
      end else begin
         unique case (pktState_r)
            mfa_pkg::MFA_IDLE: begin
               if (capture && ((|vidSelNow) || (firstNow != `MFA_SL_NONE))) begin
                  mask_r <= selMask;
                  vidSel_r <= vidSelNow;
                  vidCnt_r <= 10'h000;
                  slot_r <= firstNow;
                  pktState_r <= (|vidSelNow) ? mfa_pkg::MFA_VIDEO : mfa_pkg::MFA_WORDS;
               end
            end
            mfa_pkg::MFA_VIDEO: begin
               if (pktAdv) begin
                  if (!vidDone) begin
                     pktData_r <= vidWord;
                     pktValid_r <= 1'b1;
                     pktLast_r <= vidLastPix & (slot_r == `MFA_SL_NONE);
                     vidCnt_r <= vidCnt_r + 10'h001;
                  end else begin
                     pktValid_r <= 1'b0;
                     pktLast_r <= 1'b0;
                     pktState_r <= mfa_pkg::MFA_WORDS;
                  end
               end
            end
            mfa_pkg::MFA_WORDS: begin
               if (pktAdv) begin
                  if (slot_r != `MFA_SL_NONE) begin
                     pktData_r <= frameWord_r[slot_r];
                     pktValid_r <= 1'b1;
                     pktLast_r <= (slotNext == `MFA_SL_NONE);
                     slot_r <= slotNext;
                  end else begin
                     pktValid_r <= 1'b0;
                     pktLast_r <= 1'b0;
                     frameCnt_r <= frameCnt_r + 16'h0001;
                     pktState_r <= mfa_pkg::MFA_IDLE;
                  end
               end
            end
         endcase
      end
   end

   always_ff @(posedge core_clk) begin
      if (capture) begin
         for (int i = 0; i < `MFA_NSLOT; i++) begin
            frameWord_r[i] <= fmtWord[i];
         end
      end
   end

   // =====================================
   // Serial link: three flagged bytes per value, low byte first
   wire [3:0] serCode = serVal_r ? serCode1_r : serCode0_r;
   wire [17:0] serData = serTrunc(serCode, frameWord_r[serCode]);
   wire serLastVal = serVal_r | ~serTwo_r;
   wire [7:0] serNext = (serPos_r == 2'h0) ? {2'b00, serData[5:0]} :
                        (serPos_r == 2'h1) ? {2'b01, serData[11:6]} :
                        {~serLastVal, 1'b0, serData[17:12]};
   wire serAdv = ~serValid_r | serReady;
   wire serEnd = serLastVal & (serPos_r == 2'h3);

   assign serByte = serByte_r;
   assign serValid = serValid_r;

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         serState_r <= mfa_pkg::MFA_SIDLE;
         serCode0_r <= `MFA_SL_NONE;
         serCode1_r <= `MFA_SL_NONE;
         serTwo_r <= 1'b0;
         serVal_r <= 1'b0;
         serPos_r <= 2'h0;
         serByte_r <= 8'h00;
         serValid_r <= 1'b0;
      end else begin
         unique case (serState_r)
            mfa_pkg::MFA_SIDLE: begin
               if (capture && serStart) begin
                  serCode0_r <= ok0 ? cfgCode0 : cfgCode1;
                  serCode1_r <= cfgCode1;
                  serTwo_r <= ok0 & ok1;
                  serVal_r <= 1'b0;
                  serPos_r <= 2'h0;
                  serState_r <= mfa_pkg::MFA_SSEND;
               end
            end
            mfa_pkg::MFA_SSEND: begin
               if (serAdv) begin
                  if (serEnd) begin
                     serValid_r <= 1'b0;
                     serState_r <= mfa_pkg::MFA_SIDLE;
                  end else if (serPos_r == 2'h3) begin
                     serValid_r <= 1'b0;
                     serVal_r <= 1'b1;
                     serPos_r <= 2'h0;
                  end else begin
                     serByte_r <= serNext;
                     serValid_r <= 1'b1;
                     serPos_r <= serPos_r + 2'h1;
                  end
               end
            end
         endcase
      end
   end

   // =====================================
   // Register file and bus answers
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         sel1_r <= `MFA_RST_SEL1;
         sel2_r <= `MFA_RST_SEL2;
         serCfg_r <= `MFA_RST_SER;
         dropCnt_r <= 16'h0000;
         bvalid_r <= 1'b0;
         bresp_r <= `MFA_RESP_OK;
         rvalid_r <= 1'b0;
         rresp_r <= `MFA_RESP_OK;
         rdata_r <= 32'h0000_0000;
      end else begin
         if (wrSel1) begin
            sel1_r <= wrStrobe(sel1_r, s_axi_wdata, s_axi_wstrb);
         end
         if (wrSel2) begin
            sel2_r <= wrStrobe(sel2_r, s_axi_wdata, s_axi_wstrb);
         end
         if (wrSer) begin
            serCfg_r <= wrStrobe(serCfg_r, s_axi_wdata, s_axi_wstrb);
         end
         // Saturates so software can tell "many" from a wrapped count
         if (sampleValid && !capture && (dropCnt_r != 16'hffff)) begin
            dropCnt_r <= dropCnt_r + 16'h0001;
         end
         if (wrFire) begin
            bvalid_r <= 1'b1;
            bresp_r <= wrMapped ? `MFA_RESP_OK : `MFA_RESP_ERR;
         end else if (s_axi_bready) begin
            bvalid_r <= 1'b0;
         end
         if (rdFire) begin
            rvalid_r <= 1'b1;
            rdata_r <= rdMux;
            rresp_r <= rdMapped ? `MFA_RESP_OK : `MFA_RESP_ERR;
         end else if (s_axi_rready) begin
            rvalid_r <= 1'b0;
         end
      end
   end
endmodule

// *** verification/mfa_sink.sv ***
`timescale 1ns/1ps
// =====================================
// Frame receiver: takes packet words and serial bytes, promptly or with stalls
module mfa_sink (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic slow,
   output logic pktReady,
   output logic serReady
);
   logic [7:0] pat_r;
   // Pseudo-random stalls reach every byte and word position
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         pat_r <= 8'h5b;
         pktReady <= 1'b0;
         serReady <= 1'b0;
      end else begin
         pat_r <= {pat_r[6:0], pat_r[7] ^ pat_r[5] ^ pat_r[4] ^ pat_r[3]};
         pktReady <= !slow | pat_r[0];
         serReady <= !slow | pat_r[3];
      end
   end
endmodule

// *** verification/mfa_chk.sv ***
`timescale 1ns/1ps
// =====================================
// Stream and bus checker
module mfa_chk (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   input wire logic [31:0] pktData,
   input wire logic pktValid,
   input wire logic pktLast,
   input wire logic pktReady,
   input wire logic [7:0] serByte,
   input wire logic serValid,
   input wire logic serReady
);
   logic [1:0] bytePos_r;
   logic moreValues_r;
   wire logic serTake;
   assign serTake = serValid & serReady;
   // Position is counted, since a final high byte carries the same flags as a low byte
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         bytePos_r <= 2'h0;
         moreValues_r <= 1'b0;
      end else if (serTake) begin
         bytePos_r <= (bytePos_r == 2'h2) ? 2'h0 : bytePos_r + 2'h1;
         if (bytePos_r == 2'h2) begin
            moreValues_r <= serByte[7];
         end
      end
   end
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!rst_n);
   sequence lowTaken;
      serTake && bytePos_r == 2'h0;
   endsequence
   sequence midShown;
      serValid && serByte[7:6] == 2'b01;
   endsequence
   chk_ser_mid: assert property (lowTaken |-> ##[1:2] midShown)
      else $error("middle byte does not follow low byte");
   chk_ser_high: assert property (serTake && bytePos_r == 2'h1 |-> ##[1:2] serValid && !serByte[6])
      else $error("high byte does not follow middle byte");
   chk_ser_two_max: assert property (serTake && bytePos_r == 2'h2 && serByte[7] |-> !moreValues_r)
      else $error("more than two serial values in one sample");
   chk_ser_hold: assert property (serValid && !serReady |=> serValid && $stable(serByte))
      else $error("serial byte changed while stalled");
   chk_pkt_hold: assert property (pktValid && !pktReady |=> pktValid && $stable({pktLast, pktData}))
      else $error("packet word changed while stalled");
   chk_pkt_flow: assert property (pktValid && pktReady && !pktLast |=> ##[0:1] pktValid)
      else $error("gap inside frame");
   chk_pkt_end: assert property (pktValid && pktReady && pktLast |=> !pktValid [*2])
      else $error("word after frame end");
   chk_axi_bresp: assert property (s_axi_awvalid && s_axi_wvalid && s_axi_awready |=> s_axi_bvalid && !s_axi_awready)
      else $error("write response late");
   chk_axi_rdata: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
      else $error("read data late");
endmodule
bind measurement_frame_assembler mfa_chk mfa_chk_inst (.core_clk, .rst_n, .s_axi_awvalid,
   .s_axi_wvalid, .s_axi_awready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
   .pktData, .pktValid, .pktLast, .pktReady, .serByte, .serValid, .serReady);

// *** verification/tb.sv ***
`timescale 1ns/1ps
`include "mfa_params.svh"
module tb;
   logic core_clk = 1'b0;
   logic rst_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
   logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, sampleValid;
   logic triggerFlag, triggerId, pktValid, pktLast, pktReady, serValid, serReady, slow;
   logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb, axiSeen;
   logic [1:0] s_axi_bresp, s_axi_rresp, ledColour;
   logic [31:0] s_axi_wdata, s_axi_rdata, timeStamp, displacement1, displacement2, difference;
   logic [31:0] statMin, statMax, peak_to_peak_statistic, pktData, lfsr_r = 32'h0000_2b2a;
   logic [16:0] exposureTime;
   logic [23:0] sampleCount;
   logic [9:0] temperatureQ, rawIntensity1, rawIntensity2;
   logic [10:0] peakMax1, peakMax2;
   logic [13:0] trigger_event_count, triggered_sample_count;
   logic [15:0] pixRaw, pixCorrected;
   logic [6:0] errorFlags;
   logic [8:0] pixAddr;
   logic [7:0] serByte;
   logic [31:0] r [12];
   logic [33:0] pktQ [$], serQ [$], bQ [$], rQ [$];
   int errors = 0;
   int compares = 0;
   localparam logic [31:0] CFG [5][3] = '{'{32'h0009_353f, 32'h0000_01c1, 32'h0000_0120},
      '{32'h0001_0009, 32'h0000_0000, 32'h0000_0181}, '{32'h0000_1502, 32'h0000_0040, 32'h0000_0154},
      '{32'h0009_353c, 32'h0000_01c1, 32'h0000_01da}, '{32'h0000_0000, 32'h0000_0000, 32'h0000_0193}};
   measurement_frame_assembler measurement_frame_assembler_inst (.*);
   mfa_sink mfa_sink_inst (.core_clk, .rst_n, .slow, .pktReady, .serReady);
   always #25 core_clk = ~core_clk;
   // =====================================
   // Video memory and helpers
   assign pixRaw = {7'h2b, pixAddr};
   assign pixCorrected = {pixAddr, 7'h55};
   assign axiSeen = {s_axi_rvalid, s_axi_arready, s_axi_bvalid, s_axi_awready & s_axi_wready};
   function automatic logic [31:0] rnd();
      lfsr_r = {lfsr_r[30:0], ^(lfsr_r & 32'h8020_0003)};
      return lfsr_r;
   endfunction
   task automatic report_and_stop();
      $display("errors %0d compares %0d", errors, compares);
      if (errors == 0 && compares > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task automatic check(input string what, input logic [33:0] seen, input logic [33:0] exp);
      compares++;
      if (seen !== exp) begin
         errors++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic take(input string what, ref logic [33:0] q [$], input logic [33:0] seen);
      check(what, seen, q.size() ? q.pop_front() : 34'bz);
   endtask
   task automatic waitSig(input int s);
      int n;
      n = 0;
      do begin
         @(posedge core_clk);
         n++;
      end while (!axiSeen[s] && n < 100);
      if (n >= 100) begin
         check("bus wait", 34'h1, 34'h0);
         report_and_stop();
      end
   endtask
   task automatic axi(input logic wr, input logic [3:0] a, input logic [31:0] d);
      if (wr) begin
         bQ.push_back(34'h0);
         {s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {a, d, 3'b111};
         waitSig(0);
         {s_axi_awvalid, s_axi_wvalid} <= 2'b00;
      end else begin
         rQ.push_back({2'b00, d});
         {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'b11};
         waitSig(2);
         s_axi_arvalid <= 1'b0;
      end
      waitSig(wr ? 1 : 3);
      {s_axi_bready, s_axi_rready} <= 2'b00;
      @(posedge core_clk);
   endtask
   task automatic loadFields(input int k);
      foreach (r[i])
         r[i] = rnd();
      // Early frames push temperature past both clamp limits
      if (k < 2)
         r[3] = k ? 32'h0000_01ff : 32'h0000_0200;
      {exposureTime, sampleCount, timeStamp, temperatureQ} <= {r[0][16:0], r[1][23:0], r[2], r[3][9:0]};
      {displacement1, displacement2, difference} <= {r[4], r[5], r[10]};
      {peakMax1, rawIntensity1, peakMax2, rawIntensity2} <= {r[6][20:0], r[7][20:0]};
      {ledColour, triggerFlag, errorFlags} <= r[8][9:0];
      {triggerId, trigger_event_count, triggered_sample_count} <= r[9][28:0];
      {statMin, statMax, peak_to_peak_statistic} <= {r[11], ~r[11], r[11] ^ r[4]};
   endtask
   // =====================================
   // One sample: configure, note expected words and bytes, capture, drain
   task automatic frame(input int k);
      logic [31:0] s1, s2, sr;
      logic [31:0] w [14];
      logic [31:0] fq [$];
      logic [13:0] en;
      logic [17:0] dv;
      logic [3:0] c;
      logic signed [9:0] t;
      int n;
      {s1, s2, sr} = {CFG[k][0], CFG[k][1], CFG[k][2]};
      axi(1, `MFA_ADDR_SEL1, s1);
      axi(1, `MFA_ADDR_SEL2, s2);
      axi(1, `MFA_ADDR_SER, sr);
      slow <= k[0];
      loadFields(k);
      t = r[3][9:0];
      if (t < $signed(`MFA_TMP_MIN))
         t = `MFA_TMP_MIN;
      if (t > $signed(`MFA_TMP_MAX))
         t = `MFA_TMP_MAX;
      w = '{{15'h0000, r[0][16:0]}, {8'h00, r[1][23:0]}, r[2], {{22{t[9]}}, t},
         {7'h00, r[6][20:10], 4'h0, r[6][9:0]}, r[4], {7'h00, r[7][20:10], 4'h0, r[7][9:0]},
         r[5], {14'h0000, r[8][9:7], 8'h00, r[8][6:0]},
         {r[9][28], 1'b0, r[9][27:14], 2'b00, r[9][13:0]}, r[10], r[11], ~r[11], r[11] ^ r[4]};
      en = {s2[8], s2[7], s2[6], s2[0] & s1[12] & s1[13], s1[19], s1[16], s1[10] & s1[13],
         s1[8] & s1[10] & s1[13], s1[10] & s1[12], s1[8] & s1[10] & s1[12], s1[5:2]};
      if (s1[0] | s1[1]) begin
         for (int p = 0; p < 512; p++)
            fq.push_back(s1[0] & s1[1] ? {9'(p), 7'h55, 7'h2b, 9'(p)} :
               {16'h0000, s1[0] ? {7'h2b, 9'(p)} : {9'(p), 7'h55}});
      end
      for (int i = 0; i < `MFA_NSLOT; i++)
         if (en[i])
            fq.push_back(w[i]);
      foreach (fq[i])
         pktQ.push_back({1'b0, i == fq.size() - 1, fq[i]});
      for (int v = 0; v < 2 && sr[`MFA_SER_EN]; v++) begin
         c = v ? sr[7:4] : sr[3:0];
         if (c == `MFA_SL_TRG || c >= `MFA_NSLOT) continue;
         dv = (c == `MFA_SL_TS) ? r[2][25:8] : w[c][17:0];
         if (c == `MFA_SL_I1 || c == `MFA_SL_I2)
            dv = {8'h00, w[c][9:0]};
         serQ.push_back(34'({2'b00, dv[5:0]}));
         serQ.push_back(34'({2'b01, dv[11:6]}));
         serQ.push_back(34'({2'b10, dv[17:12]}));
      end
      if (serQ.size())
         serQ[$][7] = 1'b0;
      sampleValid <= 1'b1;
      @(posedge core_clk);
      sampleValid <= 1'b0;
      // A second sample while busy must be dropped and counted
      if (k == 0) begin
         repeat (3) @(posedge core_clk);
         sampleValid <= 1'b1;
         @(posedge core_clk);
         sampleValid <= 1'b0;
      end
      n = 0;
      while ((pktQ.size() || serQ.size()) && n < 5000) begin
         @(posedge core_clk);
         n++;
      end
      if (n >= 5000) begin
         check("frame wait", 34'h1, 34'h0);
         report_and_stop();
      end
      repeat (6) @(posedge core_clk);
   endtask
   always @(posedge core_clk) begin
      if (pktValid && pktReady)
         take("packet word", pktQ, {1'b0, pktLast, pktData});
      if (serValid && serReady)
         take("serial byte", serQ, 34'(serByte));
      if (s_axi_bvalid && s_axi_bready)
         take("write response", bQ, {s_axi_bresp, 32'h0000_0000});
      if (s_axi_rvalid && s_axi_rready)
         take("read data", rQ, {s_axi_rresp, s_axi_rdata});
   end
   // =====================================
   // Main sequence
   initial begin
      {rst_n, sampleValid, slow, s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 6'h00;
      {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata} <= 42'h0;
      s_axi_wstrb <= 4'hf;
      loadFields(9);
      repeat (20) @(posedge core_clk);
      rst_n <= 1'b1;
      axi(0, `MFA_ADDR_SEL1, `MFA_RST_SEL1);
      axi(0, `MFA_ADDR_SEL2, `MFA_RST_SEL2);
      axi(0, `MFA_ADDR_SER, `MFA_RST_SER);
      axi(1, `MFA_ADDR_STAT, 32'hffff_ffff);
      axi(0, `MFA_ADDR_STAT, 32'h0000_0000);
      for (int k = 0; k < 5; k++)
         frame(k);
      axi(0, `MFA_ADDR_STAT, 32'h0001_0010);
      check("queues empty", 34'(pktQ.size() + serQ.size() + bQ.size() + rQ.size()), 34'h0);
      report_and_stop();
   end
endmodule
